// >>> verilog/cps_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Included by its bare name
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH
`define CPS_OFF_CTRL      8'h00
`define CPS_OFF_STATUS    8'h04
`define CPS_OFF_CODES     8'h08
`define CPS_OFF_UNMASK    8'h0c
`define CPS_OFF_DATA      8'h10
`define CPS_CTRL_EN       0
`define CPS_CTRL_RISE     1
`define CPS_CTRL_HS_POL   2
`define CPS_CTRL_VS_POL   3
`define CPS_CTRL_EMB      4
`define CPS_CTRL_MODE2    5
`define CPS_CTRL_COMP     6
`define CPS_CTRL_WID_LO   7
`define CPS_CTRL_WID_HI   8
`define CPS_CTRL_RST      32'h0000_0002
`define CPS_CODES_RST     32'hff_03_02_01
`define CPS_UNMASK_RST    32'hffff_ffff
`define CPS_STALL_CYCLES  1024
`endif

// >>> verilog/cps_pkg.sv
// Purpose: Types shared by the camera port files
// Assumes: Nothing
// Notes:   One-hot state codes written out
package cps_pkg;
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_WAIT_FE = 5'h02,
    ST_WAIT_FS = 5'h04,
    ST_FRAME   = 5'h08,
    ST_LINE    = 5'h10
  } cps_state_t;
  typedef enum logic [1:0] {
    WID_8  = 2'h0,
    WID_10 = 2'h1,
    WID_12 = 2'h2,
    WID_14 = 2'h3
  } cps_width_t;
endpackage : cps_pkg

// >>> verilog/cps_sync2.sv
// Purpose: Two-flop synchroniser for a bundle of levels
// Assumes: Inputs are independent levels
// Notes:   First stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module cps_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          q[i]      <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule : cps_sync2
`default_nettype wire

// >>> verilog/cps_delim.sv
// Purpose: Finds the 0xff 00 00 prefix and flags the variable byte
// Assumes: Bytes arrive with a one-cycle valid
// Notes:   Reserved values never count as image data in embedded sync mode
`timescale 1ns/1ns
`default_nettype none
module cps_delim (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  // Byte stream
  input  wire logic       vld,
  input  wire logic [7:0] byte_in,
  // Results
  output logic            code_vld,
  output logic            is_delim
);
  logic [1:0] seen_q;
  assign code_vld = vld & (seen_q == 2'h3);
  assign is_delim = code_vld | (byte_in == 8'hff) | (byte_in == 8'h00);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 2'h0;
    end else if (clr) begin
      seen_q <= 2'h0;
    end else if (vld) begin
      if (byte_in == 8'hff) begin
        seen_q <= 2'h1;
      end else if (byte_in == 8'h00 && seen_q != 2'h0 && seen_q != 2'h3) begin
        seen_q <= seen_q + 2'h1;
      end else begin
        seen_q <= 2'h0;
      end
    end
  end
endmodule : cps_delim
`default_nettype wire

// >>> verilog/cps_camera_port.sv
// Purpose: Sync front end of a parallel camera port with APB registers
// Assumes: mclk at least 2.5x pixel clock; pins are asynchronous
// Notes:   Emits line/frame events and packed words toward the packer/FIFO
`timescale 1ns/1ns
`default_nettype none
`include "cps_consts.svh"
module cps_camera_port #(
  parameter int DW          = 14,
  parameter int STALL_CYCLES = `CPS_STALL_CYCLES
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_b,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Camera pins
  input  wire logic          pixel_clock_in,
  input  wire logic          line_sync_in,
  input  wire logic          frame_sync_in,
  input  wire logic [DW-1:0] cam_data,
  // Toward packing and FIFO
  output logic [31:0]        packed_pixel_word,
  output logic               word_vld,
  output logic               frame_start,
  output logic               frame_end,
  output logic               line_start,
  output logic               line_end,
  output logic               sync_err
);
  // Reset release
  logic [1:0] rst_sh_q;
  logic       rst_n;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) rst_sh_q <= 2'h0;
    else        rst_sh_q <= {rst_sh_q[0], 1'b1};
  end
  assign rst_n = rst_sh_q[1];

  // Registers
  logic [31:0] ctrl_q, codes_q, unmask_q, data_q;
  logic        err_flag_q;
  wire         en      = ctrl_q[`CPS_CTRL_EN];
  wire         emb     = ctrl_q[`CPS_CTRL_EMB];
  wire         mode2   = ctrl_q[`CPS_CTRL_MODE2];
  wire         comp    = ctrl_q[`CPS_CTRL_COMP];
  wire cps_pkg::cps_width_t wid = cps_pkg::cps_width_t'(ctrl_q[`CPS_CTRL_WID_HI:`CPS_CTRL_WID_LO]);
  wire [7:0]   fs_code = codes_q[7:0];
  wire [7:0]   ls_code = codes_q[15:8];
  wire [7:0]   le_code = codes_q[23:16];
  wire [7:0]   fe_code = codes_q[31:24];

  // Pin synchronisers
  logic [DW+2:0] pins_s;
  cps_sync2 #(.W(DW + 3)) u_sync (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     ({pixel_clock_in, frame_sync_in, line_sync_in, cam_data}),
    .q     (pins_s)
  );
  logic          pclk_d_q;
  wire           pclk_s = pins_s[DW+2];
  wire           vs_s   = pins_s[DW+1];
  wire           hs_s   = pins_s[DW];
  wire [DW-1:0]  dat_s  = pins_s[DW-1:0];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pclk_d_q <= 1'b0;
    else        pclk_d_q <= pclk_s;
  end
  wire rise = pclk_s & ~pclk_d_q;
  wire fall = ~pclk_s & pclk_d_q;
  wire samp = en & (ctrl_q[`CPS_CTRL_RISE] ? rise : fall);

  // Width selection
  wire [13:0] dat_w = 14'(dat_s);
  wire [13:0] wmask = (wid == cps_pkg::WID_8)  ? 14'h00ff :
                      (wid == cps_pkg::WID_10) ? 14'h03ff :
                      (wid == cps_pkg::WID_12) ? 14'h0fff : 14'h3fff;
  wire [13:0] pix   = dat_w & wmask;
  wire [7:0]  byte8 = dat_w[7:0];

  // Hardware sync levels
  wire vs_act = vs_s == ctrl_q[`CPS_CTRL_VS_POL];
  wire hs_act = hs_s == ctrl_q[`CPS_CTRL_HS_POL];
  logic vs_prev_q, hs_prev_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vs_prev_q <= 1'b1;
      hs_prev_q <= 1'b1;
    end else if (samp) begin
      vs_prev_q <= vs_act;
      hs_prev_q <= hs_act;
    end
  end

  // Embedded delimiter detection
  logic code_vld, is_delim;
  cps_delim u_delim (
    .clk      (mclk),
    .rst_n    (rst_n),
    .clr      (~en),
    .vld      (samp & emb),
    .byte_in  (byte8),
    .code_vld (code_vld),
    .is_delim (is_delim)
  );
  function automatic logic code_hit(input logic [7:0] rx, input logic [7:0] prog, input logic [7:0] msk);
    code_hit = ((rx ^ prog) & msk) == 8'h00;
  endfunction
  wire m_fs = code_hit(byte8, fs_code, unmask_q[7:0]);
  wire m_ls = code_hit(byte8, ls_code, unmask_q[15:8]);
  wire m_le = code_hit(byte8, le_code, unmask_q[23:16]);
  wire m_fe = (fe_code == 8'hff) ? ~(m_fs | m_ls | m_le)
                                 : code_hit(byte8, fe_code, unmask_q[31:24]);
  // BT.656 style: bit5 blanking, bit4 end of line
  wire b_blank = byte8[5];
  wire b_eav   = byte8[4];

  cps_pkg::cps_state_t st_q, st_d;
  logic blank_q;
  wire in_frame = (st_q == cps_pkg::ST_FRAME) | (st_q == cps_pkg::ST_LINE);

  // Events per sync mode
  logic ev_fs, ev_fe, ev_ls, ev_le;
  always_comb begin
    ev_fs = 1'b0;
    ev_fe = 1'b0;
    ev_ls = 1'b0;
    ev_le = 1'b0;
    if (emb) begin
      if (code_vld && mode2) begin
        ev_fs = m_fs;
        ev_fe = m_fe;
        ev_ls = m_ls;
        ev_le = m_le;
      end else if (code_vld) begin
        ev_fe = b_blank & ~blank_q;
        ev_fs = ~b_blank & blank_q & ~b_eav;
        ev_ls = ~b_blank & ~b_eav;
        ev_le = ~b_blank & b_eav;
      end
    end else if (samp) begin
      ev_fe = vs_act & ~vs_prev_q;
      ev_fs = ~vs_act & vs_prev_q;
      ev_ls = ~vs_act & ~hs_act & hs_prev_q;
      ev_le = ~vs_act & hs_act & ~hs_prev_q;
    end
  end

  // Sync errors inside a frame: line start inside a line, line end outside one
  wire err = in_frame & ((ev_ls & (st_q == cps_pkg::ST_LINE) & ~ev_le) |
                         (ev_le & (st_q == cps_pkg::ST_FRAME) & ~ev_ls));

  always_comb begin
    st_d = st_q;
    case (st_q)
      cps_pkg::ST_IDLE:    if (en) st_d = cps_pkg::ST_WAIT_FE;
      cps_pkg::ST_WAIT_FE: if (ev_fe) st_d = cps_pkg::ST_WAIT_FS;
      cps_pkg::ST_WAIT_FS: if (ev_fs) st_d = ev_ls ? cps_pkg::ST_LINE : cps_pkg::ST_FRAME;
      cps_pkg::ST_FRAME:   if (ev_fe) st_d = cps_pkg::ST_WAIT_FS;
                           else if (ev_ls) st_d = cps_pkg::ST_LINE;
      cps_pkg::ST_LINE:    if (ev_fe) st_d = cps_pkg::ST_WAIT_FS;
                           else if (ev_le) st_d = cps_pkg::ST_FRAME;
      default:             st_d = cps_pkg::ST_IDLE;
    endcase
    if (err) st_d = cps_pkg::ST_WAIT_FS;
    if (!en) st_d = cps_pkg::ST_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= cps_pkg::ST_IDLE;
      blank_q <= 1'b1;
    end else begin
      st_q <= st_d;
      if (!en) blank_q <= 1'b1;
      else if (code_vld) blank_q <= b_blank;
    end
  end

  // Pixel acceptance
  wire hw_ok  = ~emb & ~vs_act & ~hs_act & (st_q == cps_pkg::ST_LINE | st_q == cps_pkg::ST_FRAME);
  wire emb_ok = emb & ~is_delim & (st_q == cps_pkg::ST_LINE);
  wire pix_ok = samp & (hw_ok | emb_ok) & ~err;

  // Stall watch for compressed streams
  localparam int SW = $clog2(STALL_CYCLES + 1);
  logic [SW-1:0] stall_q;
  logic          padded_q;
  wire           stall_hit = comp & ~emb & in_frame & ~padded_q & (stall_q == SW'(STALL_CYCLES));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stall_q  <= '0;
      padded_q <= 1'b0;
    end else if (pix_ok || !in_frame) begin
      stall_q  <= '0;
      padded_q <= 1'b0;
    end else begin
      if (stall_q != SW'(STALL_CYCLES)) stall_q <= stall_q + SW'(1);
      if (stall_hit) padded_q <= 1'b1;
    end
  end

  // Word packing
  logic [31:0] acc_q;
  logic [1:0]  cnt_q;
  wire         narrow = wid == cps_pkg::WID_8;
  wire         flush  = (ev_fe & in_frame) | stall_hit;
  wire [1:0]   last   = narrow ? 2'h3 : 2'h1;
  wire [4:0]   sh     = narrow ? {cnt_q, 3'h0} : {cnt_q[0], 4'h0};
  wire [31:0]  ins    = acc_q | (32'(pix) << sh);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q             <= 32'h0;
      cnt_q             <= 2'h0;
      packed_pixel_word <= 32'h0;
      word_vld          <= 1'b0;
    end else begin
      word_vld <= 1'b0;
      if (err || !en) begin
        acc_q <= 32'h0;
        cnt_q <= 2'h0;
      end else if (pix_ok) begin
        if (cnt_q == last) begin
          packed_pixel_word <= ins;
          word_vld          <= 1'b1;
          acc_q             <= 32'h0;
          cnt_q             <= 2'h0;
        end else begin
          acc_q <= ins;
          cnt_q <= cnt_q + 2'h1;
        end
      end else if (flush && cnt_q != 2'h0) begin
        packed_pixel_word <= acc_q;
        word_vld          <= 1'b1;
        acc_q             <= 32'h0;
        cnt_q             <= 2'h0;
      end
    end
  end

  // Event outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_start <= 1'b0;
      frame_end   <= 1'b0;
      line_start  <= 1'b0;
      line_end    <= 1'b0;
      sync_err    <= 1'b0;
    end else begin
      frame_start <= en & ev_fs & (st_q == cps_pkg::ST_WAIT_FS);
      frame_end   <= en & ev_fe & in_frame;
      line_start  <= en & ev_ls & ((st_q == cps_pkg::ST_FRAME) | ((st_q == cps_pkg::ST_WAIT_FS) & ev_fs)) & ~err;
      line_end    <= en & ev_le & (st_q == cps_pkg::ST_LINE) & ~err;
      sync_err    <= en & err;
    end
  end

  // APB slave
  wire acc  = psel & penable;
  wire done = acc & pready;
  wire hit  = (paddr == `CPS_OFF_CTRL) | (paddr == `CPS_OFF_STATUS) | (paddr == `CPS_OFF_CODES) |
              (paddr == `CPS_OFF_UNMASK) | (paddr == `CPS_OFF_DATA);
  wire [31:0] status = {24'h0, err_flag_q, vs_s, hs_s, st_q};
  wire [31:0] rmux = (paddr == `CPS_OFF_CTRL)   ? ctrl_q   :
                     (paddr == `CPS_OFF_STATUS) ? status   :
                     (paddr == `CPS_OFF_CODES)  ? codes_q  :
                     (paddr == `CPS_OFF_UNMASK) ? unmask_q :
                     (paddr == `CPS_OFF_DATA)   ? data_q   : 32'h0;
  wire wr = done & pwrite & ~pslverr;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0;
      ctrl_q     <= `CPS_CTRL_RST;
      codes_q    <= `CPS_CODES_RST;
      unmask_q   <= `CPS_UNMASK_RST;
      data_q     <= 32'h0;
      err_flag_q <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc && !pready) prdata <= (pwrite || !hit) ? 32'h0 : rmux;
      if (wr && paddr == `CPS_OFF_CTRL)   ctrl_q   <= {23'h0, pwdata[8:0]};
      if (wr && paddr == `CPS_OFF_CODES)  codes_q  <= pwdata;
      if (wr && paddr == `CPS_OFF_UNMASK) unmask_q <= pwdata;
      if (word_vld) data_q <= packed_pixel_word;
      if (en && err) err_flag_q <= 1'b1;
      else if (wr && paddr == `CPS_OFF_STATUS && pwdata[7]) err_flag_q <= 1'b0;
    end
  end
endmodule : cps_camera_port
`default_nettype wire

// >>> verification/cps_cam_model.sv
// Purpose: Behavioural camera driving pixel clock, syncs and data
// Assumes: Data launched while the pixel clock is low, period 80 ns
// Notes:   Clock stands still between calls; released data is inverted
`timescale 1ns/1ns
`default_nettype none
module cps_cam_model (
  // Camera pins
  output logic        pclk,
  output logic        hs,
  output logic        vs,
  output logic [13:0] d
);
  initial begin
    pclk = 1'b0;
    hs   = 1'b0;
    vs   = 1'b0;
    d    = 14'h0;
  end
  // One pixel period, slow enough for the system clock
  task automatic beat(input logic [7:0] b, input logic h, input logic v);
    d  = {6'h2a, b};
    hs = h;
    vs = v;
    #40 pclk = 1'b1;
    #40 pclk = 1'b0;
  endtask : beat
  // Common prefix then the variable byte; syncs parked active
  task automatic code(input logic [7:0] c);
    beat(8'hff, 1'b1, 1'b1);
    beat(8'h00, 1'b1, 1'b1);
    beat(8'h00, 1'b1, 1'b1);
    beat(c, 1'b1, 1'b1);
  endtask : code
  // Bit 8 set marks a delimiter; image bytes avoid 00 and ff
  task automatic play(input logic [8:0] s[$]);
    foreach (s[i]) begin
      if (s[i][8])
        code(s[i][7:0]);
      else
        beat(s[i][7:0], 1'b1, 1'b1);
    end
  endtask : play
  task automatic rel();
    d = ~d;
  endtask : rel
endmodule : cps_cam_model
`default_nettype wire

// >>> verification/cps_camera_port_monitor.sv
// Purpose: Port-level assertions for the camera port
// Assumes: Enable and frame/line position shadowed from ports
// Notes:   Bound into every cps_camera_port
`timescale 1ns/1ns
`default_nettype none
`include "cps_consts.svh"
module cps_camera_port_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events
  input wire logic        word_vld,
  input wire logic        frame_start,
  input wire logic        frame_end,
  input wire logic        line_start,
  input wire logic        line_end,
  input wire logic        sync_err
);
  logic en_q;
  logic fr_q;
  logic in_q;
  wire  ctrl_wr = psel && penable && pready && pwrite && (paddr == `CPS_OFF_CTRL);
  wire  stop    = frame_end || sync_err || !en_q;
  wire  any_ev  = word_vld || frame_start || frame_end || line_start || line_end || sync_err;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 1'b0;
      fr_q <= 1'b0;
      in_q <= 1'b0;
    end else begin
      en_q <= ctrl_wr ? pwdata[0] : en_q;
      fr_q <= stop ? 1'b0 : (frame_start || fr_q);
      in_q <= (stop || line_end) ? 1'b0 : (line_start || in_q);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_quiet;
    !word_vld && !line_start && !line_end;
  endsequence
  a_ready_answer:
    assert property (s_access |=> pready) else $error("no answer after access phase");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_unmapped_err:
    assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_mapped_ok:
    assert property (pready && paddr <= 8'h10 && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped refused");
  a_quiet_disabled:
    assert property (!en_q && !$past(en_q) |-> !any_ev) else $error("event while disabled");
  a_error_resyncs:
    assert property (sync_err |=> s_quiet [*8]) else $error("traffic right after sync error");
  a_line_end_open:
    assert property (line_end && !sync_err |-> in_q) else $error("line end outside a line");
  a_line_in_frame:
    assert property (line_start |-> fr_q || frame_start) else $error("line start outside a frame");
endmodule : cps_camera_port_monitor
bind cps_camera_port cps_camera_port_monitor u_mon (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .word_vld(word_vld),
  .frame_start(frame_start), .frame_end(frame_end), .line_start(line_start), .line_end(line_end),
  .sync_err(sync_err)
);
`default_nettype wire

// >>> verification/tb.sv
// Purpose: Self-checking bench for the camera port
// Assumes: Camera model launches data while the pixel clock is low
// Notes:   Hardware, compressed, embedded mode 2 and mode 1 passes
`timescale 1ns/1ns
`default_nettype none
`include "cps_consts.svh"
module tb;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic        pclk, hs, vs, wv, fs, fe, ls, le, se;
  logic [7:0]  paddr;
  logic [13:0] cd;
  logic [31:0] pwdata, prdata, ppw, rd;
  logic [31:0] w[$];
  int          err_count, num_checks, n_fs, n_ls, n_se;
  cps_camera_port #(.DW(14), .STALL_CYCLES(64)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pixel_clock_in(pclk),
    .line_sync_in(hs), .frame_sync_in(vs), .cam_data(cd), .packed_pixel_word(ppw), .word_vld(wv),
    .frame_start(fs), .frame_end(fe), .line_start(ls), .line_end(le), .sync_err(se)
  );
  cps_cam_model u_cam (.pclk(pclk), .hs(hs), .vs(vs), .d(cd));
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if (wv === 1'b1)
      w.push_back(ppw);
    n_fs += (fs === 1'b1);
    n_ls += (ls === 1'b1);
    n_se += (se === 1'b1);
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    for (int n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge mclk);
    if (pready !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdc
  task automatic wait_w(input int n);
    for (int i = 0; i < 4000 && w.size() < n; i++)
      @(posedge mclk);
    if (w.size() < n) begin
      err_count++;
      give_verdict();
    end
  endtask : wait_w
  initial begin
    mclk    = 1'b0;
    rst_b   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc("ctrl", `CPS_OFF_CTRL, `CPS_CTRL_RST);
    rdc("codes", `CPS_OFF_CODES, `CPS_CODES_RST);
    rdc("unmask", `CPS_OFF_UNMASK, `CPS_UNMASK_RST);
    apb(1'b1, `CPS_OFF_UNMASK, 32'h5a3c_96e1);
    rdc("unmask rw", `CPS_OFF_UNMASK, 32'h5a3c_96e1);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    // Hardware sync, 8-bit, rising edge, syncs active high
    apb(1'b1, `CPS_OFF_CTRL, 32'h0000_000f);
    u_cam.beat(8'h10, 1'b1, 1'b0);
    u_cam.beat(8'h11, 1'b0, 1'b1);
    u_cam.beat(8'h12, 1'b1, 1'b0);
    for (int i = 1; i < 7; i++)
      u_cam.beat(8'(8'h20 + i), 1'b0, 1'b0);
    u_cam.beat(8'h13, 1'b1, 1'b0);
    u_cam.beat(8'h14, 1'b1, 1'b1);
    u_cam.rel();
    wait_w(2);
    chk("hw w0", w[0], 32'h2423_2221);
    chk("hw w1", w[1], 32'h0000_2625);
    // Disabled port sees a whole frame start
    apb(1'b1, `CPS_OFF_CTRL, 32'h0000_000e);
    u_cam.beat(8'h15, 1'b0, 1'b1);
    u_cam.beat(8'h16, 1'b0, 1'b0);
    u_cam.beat(8'h17, 1'b1, 1'b1);
    chk("off fs", n_fs, 1);
    chk("off w", w.size(), 2);
    // Compressed stream stalls without frame sync change
    apb(1'b1, `CPS_OFF_CTRL, 32'h0000_004f);
    u_cam.beat(8'h10, 1'b1, 1'b0);
    u_cam.beat(8'h18, 1'b1, 1'b1);
    u_cam.beat(8'h19, 1'b1, 1'b0);
    for (int i = 1; i < 6; i++)
      u_cam.beat(8'(8'h30 + i), 1'b0, 1'b0);
    u_cam.beat(8'h1a, 1'b1, 1'b0);
    u_cam.rel();
    wait_w(4);
    chk("jpg w", w[2], 32'h3433_3231);
    chk("jpg pad", w[3], 32'h0000_0035);
    // Embedded mode 2, masked frame start, catch-all frame end
    apb(1'b1, `CPS_OFF_CTRL, 32'h0000_0000);
    n_fs = 0;
    n_ls = 0;
    apb(1'b1, `CPS_OFF_CODES, 32'hff13_12a5);
    apb(1'b1, `CPS_OFF_UNMASK, 32'hffff_1f10);
    apb(1'b1, `CPS_OFF_CTRL, 32'h0000_003f);
    u_cam.play({9'h148, 9'h112, 9'h041, 9'h177, 9'h148, 9'h112, 9'h051, 9'h052, 9'h053, 9'h054, 9'h113});
    chk("m2 fs", n_fs, 1);
    chk("m2 ls", n_ls, 1);
    u_cam.play({9'h112, 9'h061, 9'h112, 9'h062, 9'h177});
    u_cam.rel();
    wait_w(5);
    chk("m2 w", w[4], 32'h5453_5251);
    chk("m2 err", n_se, 1);
    chk("m2 n", w.size(), 5);
    // Embedded mode 1 after a clean disable
    apb(1'b1, `CPS_OFF_CTRL, 32'h0000_0000);
    apb(1'b1, `CPS_OFF_CTRL, 32'h0000_001f);
    u_cam.play({9'h180, 9'h041, 9'h190, 9'h1a0, 9'h1b0, 9'h180, 9'h071, 9'h072, 9'h073, 9'h074, 9'h190, 9'h1a0});
    u_cam.rel();
    wait_w(6);
    chk("m1 w", w[5], 32'h7473_7271);
    chk("m1 n", w.size(), 6);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
